// File: core/swd_top.sv
// fieldbus slave watchdogs and operating state machine, Avalon-MM slave
// Overview of operation
// RL1 - one multiplier register shared by both watchdogs at offset 400h
// RL2 - interface timer at 410h, bus timer at 420h, each with multiplier
// RL3 - tick is multiplier plus two 40 ns base ticks; timeout tick times timer
// RL4 - reset gives multiplier 2498 and bus timer 1000, a 100 ms timeout
// RL5 - bus watchdog restarts and clears only on process data exchange
// RL6 - bus watchdog expires after silence; operating state stays unchanged
// RL7 - an expired watchdog forces outputs to the preset safe value
// RL8 - interface watchdog expires after silence on the local processor side
// RL9 - bus timer value zero disables that watchdog and safe forcing
// RL10 - software keeps timer values at most 65535
// RL11 - after reset state is init; mailbox and process data refused
// RL12 - master sets sync channels 0 and 1 for mailbox while in init
// RL13 - init to pre-operational checks mailbox; mailbox only allowed
// RL14 - master sets process data channels from 2 in pre-operational
// RL15 - to safe-operational check settings, copy inputs before acknowledge
// RL16 - safe-operational allows all traffic, updates inputs, outputs safe
// RL17 - with watchdog disabled outputs follow data in safe-operational
// RL18 - master supplies valid output data before requesting operational
// RL19 - operational copies output data to outputs, all traffic allowed
// RL20 - boot state is entered only from init
// RL21 - boot allows only file-transfer mailbox traffic
// RL22 - per-watchdog expiry status readable, cleared when traffic resumes
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`include "swd_regs.svh"
module swd_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // traffic events and process inputs
    input swd_pkg::swd_events_t events,
    input wire logic [15:0] process_inputs,
    // granted traffic and process outputs
    output swd_pkg::swd_grant_t grant,
    output swd_pkg::swd_state_t op_state,
    output logic [15:0] process_outputs,
    output logic bus_wd_expired,
    output logic if_wd_expired
);
    import swd_pkg::*;

    typedef struct packed {
        logic [15:0] mult;
        logic [15:0] if_tmr;
        logic [15:0] bus_tmr;
        logic [2:0] req;
        logic go;
        logic mbx_ok;
        logic pd_ok;
        logic err;
        swd_state_t st;
        logic [15:0] out_data;
        logic [15:0] safe_val;
        logic [15:0] outputs;
        logic [15:0] in_copy;
        logic [1:0] div;
        logic base_tick;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        swd_grant_t grant;
        logic bus_exp;
        logic if_exp;
    } swd_regs_t;

    swd_regs_t r;
    swd_regs_t next_r;
    logic bus_exp_w;
    logic if_exp_w;
    logic bus_kick;
    logic if_kick;
    logic access;

    // merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] be);
        wr16 = old;
        if (be[0]) wr16[7:0] = d[7:0];
        if (be[1]) wr16[15:8] = d[15:8];
    endfunction : wr16

    // true when the address is a mapped register
    function automatic logic mapped(input logic [11:0] a);
        case (a)
            `SWD_OFS_MULT, `SWD_OFS_IF_TMR, `SWD_OFS_BUS_TMR,
            `SWD_OFS_CTRL, `SWD_OFS_STAT, `SWD_OFS_OUTDATA,
            `SWD_OFS_SAFEVAL, `SWD_OFS_OUTPINS,
            `SWD_OFS_INCOPY: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // traffic policy per state
    function automatic swd_grant_t grant_of(input swd_state_t s);
        grant_of = '0;
        unique case (s)
            SWD_INIT: grant_of = '0; // see RL11
            SWD_PREOP: grant_of.mbx_ok = 1'b1; // see RL13
            SWD_SAFE_OPERATIONAL_STATE, SWD_OP: begin
                grant_of.mbx_ok = 1'b1; // see RL16 see RL19
                grant_of.pd_ok = 1'b1;
            end
            SWD_BOOT: grant_of.ftm_ok = 1'b1; // see RL21
        endcase
    endfunction : grant_of

    // bus watchdog only counts exchanges that the state lets through; interface kicks are not gated
    assign bus_kick = events.bus_pd && r.grant.pd_ok; // see RL5
    assign if_kick = events.if_access;

    // interface-side watchdog
    swd_timer u_if_wd (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .base_tick(r.base_tick),
        .mult(r.mult), // see RL1
        .timer(r.if_tmr), // see RL2
        .kick(if_kick),
        .expired(if_exp_w)
    );

    // bus-side watchdog
    swd_timer u_bus_wd (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .base_tick(r.base_tick),
        .mult(r.mult), // see RL1
        .timer(r.bus_tmr), // see RL2
        .kick(bus_kick),
        .expired(bus_exp_w)
    );

    // bus handshake, register file, state machine and outputs
    always_comb begin
        next_r = r;
        access = (avs_read || avs_write) && !r.ack;
        next_r.ack = access;
        next_r.go = 1'b0;
        // 25 MHz base tick from the 100 MHz clock
        if (r.div == 2'(`SWD_BASE_DIV - 1)) begin
            next_r.div = '0;
            next_r.base_tick = 1'b1; // see RL3
        end else begin
            next_r.div = r.div + 2'h1;
            next_r.base_tick = 1'b0;
        end
        if (access) begin
            next_r.resp = mapped(avs_address) ? 2'h0 : 2'h2;
            next_r.rdata = '0;
        end
        if (access && avs_write) begin
            unique case (avs_address)
                `SWD_OFS_MULT:
                    next_r.mult = wr16(r.mult, avs_writedata,
                                       avs_byteenable); // see RL1
                `SWD_OFS_IF_TMR:
                    next_r.if_tmr = wr16(r.if_tmr, avs_writedata,
                                         avs_byteenable); // see RL2
                `SWD_OFS_BUS_TMR:
                    next_r.bus_tmr = wr16(r.bus_tmr, avs_writedata,
                                          avs_byteenable); // see RL2
                `SWD_OFS_CTRL:
                    if (avs_byteenable[0]) begin
                        next_r.req = avs_writedata[`SWD_CTRL_REQ_LSB +:
                                                   `SWD_CTRL_REQ_W];
                        next_r.go = avs_writedata[`SWD_CTRL_GO_BIT];
                        next_r.mbx_ok = avs_writedata[`SWD_CTRL_MBXOK_BIT];
                        next_r.pd_ok = avs_writedata[`SWD_CTRL_PDOK_BIT];
                    end
                `SWD_OFS_OUTDATA:
                    next_r.out_data = wr16(r.out_data, avs_writedata,
                                           avs_byteenable);
                `SWD_OFS_SAFEVAL:
                    next_r.safe_val = wr16(r.safe_val, avs_writedata,
                                           avs_byteenable);
                default: ;
            endcase
        end
        if (access && avs_read) begin
            unique case (avs_address)
                `SWD_OFS_MULT: next_r.rdata = {16'h0000, r.mult};
                `SWD_OFS_IF_TMR: next_r.rdata = {16'h0000, r.if_tmr};
                `SWD_OFS_BUS_TMR: next_r.rdata = {16'h0000, r.bus_tmr};
                `SWD_OFS_CTRL:
                    next_r.rdata = {26'h0, r.pd_ok, r.mbx_ok, 1'b0, r.req};
                `SWD_OFS_STAT:
                    next_r.rdata = {25'h0, r.err, r.if_exp, r.bus_exp,
                                    1'b0, r.st}; // see RL22
                `SWD_OFS_OUTDATA: next_r.rdata = {16'h0000, r.out_data};
                `SWD_OFS_SAFEVAL: next_r.rdata = {16'h0000, r.safe_val};
                `SWD_OFS_OUTPINS: next_r.rdata = {16'h0000, r.outputs};
                `SWD_OFS_INCOPY: next_r.rdata = {16'h0000, r.in_copy};
                default: next_r.rdata = '0;
            endcase
        end
        // state transitions on a request strobe; watchdogs never move it
        if (r.go) begin
            next_r.err = 1'b1;
            unique case (swd_state_t'(r.req))
                SWD_INIT: begin
                    next_r.st = SWD_INIT;
                    next_r.err = 1'b0;
                end
                SWD_PREOP:
                    if (r.st == SWD_INIT && r.mbx_ok) begin
                        next_r.st = SWD_PREOP; // see RL13
                        next_r.err = 1'b0;
                    end else if (r.st != SWD_BOOT && r.st != SWD_INIT) begin
                        next_r.st = SWD_PREOP;
                        next_r.err = 1'b0;
                    end
                SWD_SAFE_OPERATIONAL_STATE:
                    if ((r.st == SWD_PREOP && r.pd_ok) ||
                        r.st == SWD_OP) begin
                        next_r.st = SWD_SAFE_OPERATIONAL_STATE; // see RL15
                        next_r.in_copy = process_inputs; // see RL15
                        next_r.err = 1'b0;
                    end
                SWD_OP:
                    if (r.st == SWD_SAFE_OPERATIONAL_STATE) begin
                        next_r.st = SWD_OP; // see RL18
                        next_r.err = 1'b0;
                    end
                SWD_BOOT:
                    if (r.st == SWD_INIT) begin
                        next_r.st = SWD_BOOT; // see RL20
                        next_r.err = 1'b0;
                    end
                default: ;
            endcase
        end
        // cyclic input update while process data runs
        if (r.st == SWD_SAFE_OPERATIONAL_STATE || r.st == SWD_OP) begin
            next_r.in_copy = process_inputs; // see RL16
        end
        next_r.grant = grant_of(next_r.st);
        next_r.bus_exp = bus_exp_w; // see RL22
        next_r.if_exp = if_exp_w; // see RL22
        // outputs: data in operational or in safe-operational with bus timer zero, safe value otherwise or on expiry
        if (bus_exp_w || if_exp_w) begin
            next_r.outputs = r.safe_val; // see RL7
        end else if (r.st == SWD_OP) begin
            next_r.outputs = r.out_data; // see RL19
        end else if (r.st == SWD_SAFE_OPERATIONAL_STATE && r.bus_tmr == 16'h0000) begin
            next_r.outputs = r.out_data; // see RL17 see RL9
        end else begin
            next_r.outputs = r.safe_val; // see RL16
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.mult <= `SWD_RST_MULT; // see RL4
            r.if_tmr <= `SWD_RST_IF_TMR;
            r.bus_tmr <= `SWD_RST_BUS_TMR; // see RL4
            r.st <= SWD_INIT; // see RL11
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = r.rdata;
    assign avs_waitrequest = !r.ack;
    assign avs_response = r.resp;
    assign grant = r.grant;
    assign op_state = r.st;
    assign process_outputs = r.outputs;
    assign bus_wd_expired = r.bus_exp;
    assign if_wd_expired = r.if_exp;
endmodule : swd_top

// File: inc/swd_regs.svh
// register offsets, reset values and timing counts of the watchdog block
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH
`define SWD_OFS_MULT 12'h400
`define SWD_OFS_IF_TMR 12'h410
`define SWD_OFS_BUS_TMR 12'h420
`define SWD_OFS_CTRL 12'h430
`define SWD_OFS_STAT 12'h434
`define SWD_OFS_OUTDATA 12'h438
`define SWD_OFS_SAFEVAL 12'h43c
`define SWD_OFS_OUTPINS 12'h440
`define SWD_OFS_INCOPY 12'h444
`define SWD_RST_MULT 16'h09c2
`define SWD_RST_IF_TMR 16'h03e8
`define SWD_RST_BUS_TMR 16'h03e8
`define SWD_BASE_NS 40
`define SWD_CLK_NS 10
`define SWD_BASE_DIV (`SWD_BASE_NS / `SWD_CLK_NS)
`define SWD_CTRL_REQ_LSB 0
`define SWD_CTRL_REQ_W 3
`define SWD_CTRL_GO_BIT 3
`define SWD_CTRL_MBXOK_BIT 4
`define SWD_CTRL_PDOK_BIT 5
`define SWD_STAT_STATE_LSB 0
`define SWD_STAT_BUSEXP_BIT 4
`define SWD_STAT_IFEXP_BIT 5
`define SWD_STAT_ERR_BIT 6
`endif

// File: inc/swd_pkg.sv
// types shared by the watchdog and state machine block
package swd_pkg;
    typedef enum logic [2:0] {
        SWD_INIT = 3'h0,
        SWD_PREOP = 3'h1,
        SWD_SAFE_OPERATIONAL_STATE = 3'h3,
        SWD_OP = 3'h2,
        SWD_BOOT = 3'h6
    } swd_state_t;
    typedef struct packed {
        logic bus_pd;
        logic if_access;
    } swd_events_t;
    typedef struct packed {
        logic mbx_ok;
        logic ftm_ok;
        logic pd_ok;
    } swd_grant_t;
endpackage : swd_pkg

// File: core/swd_timer.sv
// one watchdog: tick prescaler and timeout counter
`timescale 1ns/100ps
`include "swd_regs.svh"
module swd_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // base tick and settings
    input wire logic base_tick,
    input wire logic [15:0] mult,
    input wire logic [15:0] timer,
    input wire logic kick,
    // status
    output logic expired
);
    import swd_pkg::*;
    typedef struct packed {
        logic [16:0] pre;
        logic [15:0] cnt;
        logic exp;
    } swd_tmr_t;
    swd_tmr_t r;
    swd_tmr_t next_r;
    logic [16:0] tick_len;
    assign tick_len = {1'b0, mult} + 17'h00002; // see RL3
    assign expired = r.exp;
    // prescale base ticks into watchdog ticks, count toward timeout
    always_comb begin
        next_r = r;
        if (kick || timer == 16'h0000) begin
            next_r = '0; // see RL5 see RL9
        end else if (base_tick && !r.exp) begin
            if (r.pre + 17'h00001 >= tick_len) begin
                next_r.pre = '0;
                if (r.cnt + 16'h0001 >= timer) begin
                    next_r.exp = 1'b1; // see RL3 see RL6 see RL8
                end else begin
                    next_r.cnt = r.cnt + 16'h0001;
                end
            end else begin
                next_r.pre = r.pre + 17'h00001;
            end
        end
    end
    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : swd_timer

// File: bench/swd_chk.sv
// concurrent checks on the ports of the watchdog block
`timescale 1ns/100ps
module swd_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // traffic, state and expiry
    input swd_pkg::swd_events_t events,
    input swd_pkg::swd_grant_t grant,
    input swd_pkg::swd_state_t op_state,
    input wire logic bus_wd_expired,
    input wire logic if_wd_expired
);
    import swd_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // a request taken by the slave, then its one-cycle answer
    sequence bus_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence bus_answer;
        ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_bus_answer: assert property (bus_take |-> bus_answer)
        else $error("register access not answered in one cycle");
    chk_reset_init: assert property
        ($fell(sys_rst) |-> op_state == SWD_INIT)
        else $error("state after reset is not init");
    chk_init_refuse: assert property
        (op_state == SWD_INIT && $stable(op_state) |-> grant == 3'b000)
        else $error("traffic granted in init");
    chk_preop_mbx_only: assert property
        (op_state == SWD_PREOP && $stable(op_state) |-> grant == 3'b100)
        else $error("pre-operational grant wrong");
    chk_boot_ftm_only: assert property
        (op_state == SWD_BOOT && $stable(op_state) |-> grant == 3'b010)
        else $error("boot grant wrong");
    chk_run_all_traffic: assert property
        ((op_state == SWD_SAFE_OPERATIONAL_STATE || op_state == SWD_OP) && $stable(op_state)
         |-> grant.mbx_ok && grant.pd_ok)
        else $error("running state refuses traffic");
    chk_boot_from_init: assert property
        ($changed(op_state) && op_state == SWD_BOOT
         |-> $past(op_state) == SWD_INIT)
        else $error("boot entered from a state other than init");
    chk_state_on_expiry: assert property
        ($rose(bus_wd_expired) |-> $stable(op_state))
        else $error("state changed on bus watchdog expiry");
    chk_bus_clear: assert property
        ($fell(bus_wd_expired) |-> $past(events.bus_pd)
         || $past(events.bus_pd, 2))
        else $error("bus expiry cleared without an exchange");
    chk_if_clear: assert property
        ($fell(if_wd_expired) |-> $past(events.if_access)
         || $past(events.if_access, 2))
        else $error("interface expiry cleared without an access");
endmodule : swd_chk

// File: bench/swd_master_model.sv
// fieldbus master and local processor: exchange pulses and field inputs
`timescale 1ns/100ps
module swd_master_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // pace set by the bench
    input wire logic pd_run,
    input wire logic if_run,
    input wire logic [15:0] in_level,
    // towards the block
    output swd_pkg::swd_events_t events,
    output logic [15:0] process_inputs
);
    import swd_pkg::*;
    logic [1:0] cnt;
    // one exchange pulse and one access pulse every 4 cycles while running
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt <= 2'h0;
            events <= '0;
        end else begin
            cnt <= cnt + 2'h1;
            events.bus_pd <= pd_run && cnt == 2'h3;
            events.if_access <= if_run && cnt == 2'h3;
        end
    end
    // field inputs as the process side holds them
    assign process_inputs = in_level;
endmodule : swd_master_model

// File: bench/swd_top_test.sv
// self-checking bench of the watchdog and state machine block
`timescale 1ns/100ps
`include "swd_regs.svh"
module swd_top_test;
    import swd_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    swd_events_t events;
    logic [15:0] process_inputs;
    swd_grant_t grant;
    swd_state_t op_state;
    logic [15:0] process_outputs;
    logic bus_wd_expired;
    logic if_wd_expired;
    logic pd_run = 1'b0;
    logic if_run = 1'b0;
    logic [15:0] in_level = 16'h3c96;
    logic [31:0] rd;
    logic [1:0] rs;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    swd_top dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .events, .process_inputs, .grant, .op_state,
        .process_outputs, .bus_wd_expired, .if_wd_expired);
    swd_master_model u_master (.ref_clk, .sys_rst, .pd_run, .if_run,
        .in_level, .events, .process_inputs);
    // clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // counts and verdict
    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // one avalon access, held until waitrequest is seen low
    task bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_read <= !wr;
        avs_write <= wr;
        // waits until waitrequest falls; no bound here other than the hang guard
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // state request with config flags {process data, mailbox}
    task go(input logic [2:0] s, input logic [1:0] cfg);
        bus(1'b1, `SWD_OFS_CTRL, {10'h000, cfg, 1'b1, s});
        repeat (2) @(posedge ref_clk);
    endtask : go
    // wait for an expiry flag under a bound
    task automatic wait_flag(ref logic f);
        n = 0;
        while (f !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_flag
    // reset values, read-back, unmapped place
    task t_regs();
        check(32'(op_state), SWD_INIT);
        bus(1'b0, `SWD_OFS_MULT, 16'h0);
        check(rd, 32'h9c2);
        bus(1'b0, `SWD_OFS_BUS_TMR, 16'h0);
        check(rd, 32'h3e8);
        bus(1'b1, `SWD_OFS_IF_TMR, 16'h1234);
        bus(1'b1, `SWD_OFS_BUS_TMR, 16'hffff);
        bus(1'b0, `SWD_OFS_IF_TMR, 16'h0);
        check(rd, 32'h1234);
        bus(1'b0, `SWD_OFS_BUS_TMR, 16'h0);
        check(rd, 32'hffff);
        bus(1'b1, 12'h7f0, 16'h5555);
        check(32'(rs), 32'h2);
        bus(1'b0, `SWD_OFS_MULT, 16'h0);
        check(rd, 32'h9c2);
    endtask : t_regs
    // legal and refused transitions up to operational
    task t_states();
        go(SWD_BOOT, 2'b00);
        check(32'(op_state), SWD_BOOT);
        go(SWD_INIT, 2'b00);
        go(SWD_PREOP, 2'b00);
        bus(1'b0, `SWD_OFS_STAT, 16'h0);
        check(rd[6:0], 7'h40);
        go(SWD_PREOP, 2'b01);
        check(32'(op_state), SWD_PREOP);
        go(SWD_BOOT, 2'b01);
        check(32'(op_state), SWD_PREOP);
        go(SWD_SAFE_OPERATIONAL_STATE, 2'b11);
        bus(1'b0, `SWD_OFS_INCOPY, 16'h0);
        check(rd, 32'h3c96);
        in_level <= 16'h0f0f;
        repeat (4) @(posedge ref_clk);
        bus(1'b0, `SWD_OFS_INCOPY, 16'h0);
        check(rd, 32'h0f0f);
        check(32'(process_outputs), 32'h0);
        bus(1'b1, `SWD_OFS_OUTDATA, 16'ha5c3);
        go(SWD_OP, 2'b11);
        check(32'(process_outputs), 32'ha5c3);
    endtask : t_states
    // bus watchdog: held off, expiry, safe value, recovery
    task t_bus_wd();
        pd_run <= 1'b1;
        if_run <= 1'b1;
        bus(1'b1, `SWD_OFS_SAFEVAL, 16'h5a0f);
        bus(1'b1, `SWD_OFS_MULT, 16'h0);
        bus(1'b1, `SWD_OFS_BUS_TMR, 16'h4);
        bus(1'b1, `SWD_OFS_IF_TMR, 16'h4);
        repeat (60) @(posedge ref_clk);
        check(32'(bus_wd_expired), 32'h0);
        pd_run <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check(32'(bus_wd_expired), 32'h0);
        wait_flag(bus_wd_expired);
        check(32'(n >= 20 && n <= 28), 32'h1);
        check(32'(op_state), SWD_OP);
        repeat (2) @(posedge ref_clk);
        check(32'(process_outputs), 32'h5a0f);
        bus(1'b0, `SWD_OFS_STAT, 16'h0);
        check(32'(rd[4]), 32'h1);
        pd_run <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(32'(bus_wd_expired), 32'h0);
        check(32'(process_outputs), 32'ha5c3);
    endtask : t_bus_wd
    // interface watchdog expiry and recovery
    task t_if_wd();
        if_run <= 1'b0;
        wait_flag(if_wd_expired);
        check(32'(if_wd_expired), 32'h1);
        repeat (2) @(posedge ref_clk);
        check(32'(process_outputs), 32'h5a0f);
        bus(1'b0, `SWD_OFS_STAT, 16'h0);
        check(32'(rd[5]), 32'h1);
        if_run <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(32'(if_wd_expired), 32'h0);
    endtask : t_if_wd
    // zero bus timer disables forcing, also in safe-operational
    task t_disable();
        bus(1'b1, `SWD_OFS_BUS_TMR, 16'h0);
        pd_run <= 1'b0;
        repeat (100) @(posedge ref_clk);
        check(32'(bus_wd_expired), 32'h0);
        check(32'(process_outputs), 32'ha5c3);
        go(SWD_SAFE_OPERATIONAL_STATE, 2'b11);
        check(32'(process_outputs), 32'ha5c3);
        pd_run <= 1'b1;
        bus(1'b1, `SWD_OFS_BUS_TMR, 16'h4);
        repeat (4) @(posedge ref_clk);
        check(32'(process_outputs), 32'h5a0f);
        go(SWD_INIT, 2'b00);
        check(32'(op_state), SWD_INIT);
    endtask : t_disable
    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_states();
        t_bus_wd();
        t_if_wd();
        t_disable();
        report_and_stop();
    end
endmodule : swd_top_test
bind swd_top swd_chk u_chk (.ref_clk, .sys_rst, .avs_read, .avs_write,
    .avs_waitrequest, .events, .grant, .op_state, .bus_wd_expired,
    .if_wd_expired);
